// File: core/udec_pkg.sv
package udec_pkg;
    // ---------------------------------------------
    // Register byte addresses
    // ---------------------------------------------
    localparam logic [11:0] A_IN0_MPS = 12'h900;
    localparam logic [11:0] A_IN_CTL  = 12'h920;
    localparam logic [11:0] A_EP0_CTL = 12'hb00;
    localparam logic [11:0] A_OUT_INT = 12'hb08;

    // ---------------------------------------------
    // Field positions
    // ---------------------------------------------
    localparam int B_EN    = 31;
    localparam int B_DIS   = 30;
    localparam int B_SD1   = 29;
    localparam int B_SD0   = 28;
    localparam int B_SET_NAK_CMD  = 27;
    localparam int B_CLEAR_NAK_CMD  = 26;
    localparam int B_TXF   = 22;
    localparam int B_STALL = 21;
    localparam int B_SNP   = 20;
    localparam int B_TYPE  = 18;
    localparam int B_NAK   = 17;
    localparam int B_DATA_TOGGLE_BIT  = 16;
    localparam int B_ACT   = 15;
    localparam int B_NEXT  = 11;
    localparam int B_NYET  = 14;
    localparam int B_NAKI  = 13;
    localparam int B_BBL   = 12;
    localparam int B_DROP  = 11;
    localparam int W_MPS   = 11;
    localparam int W_NEXT  = 4;

    // ---------------------------------------------
    // Codes and reset values
    // ---------------------------------------------
    localparam logic [1:0] T_CTRL = 2'h0;
    localparam logic [1:0] T_ISO  = 2'h1;
    localparam logic [1:0] T_BULK = 2'h2;
    localparam logic [1:0] T_INTR = 2'h3;
    localparam logic [1:0] TK_OUT   = 2'h0;
    localparam logic [1:0] TK_IN    = 2'h1;
    localparam logic [1:0] TK_SETUP = 2'h2;
    localparam logic [6:0] MPS_64 = 7'h40;
    localparam logic [6:0] MPS_32 = 7'h20;
    localparam logic [6:0] MPS_16 = 7'h10;
    localparam logic [6:0] MPS_8  = 7'h08;
    localparam logic [31:0] RD_NONE = 32'h0000_0000;

    typedef enum logic [2:0] {
        HS_NONE = 3'h0, HS_ACK = 3'h1, HS_NAK = 3'h2,
        HS_STALL = 3'h3, HS_DATA = 3'h4, HS_ZLP = 3'h5
    } udec_hs_t;

    typedef enum logic [1:0] {
        BS_IDLE = 2'b01, BS_ANS = 2'b10
    } udec_bus_t;
endpackage

// File: core/udec_top.sv
`timescale 1ns/1ps
// How it works
// - Stall beats NAK and global OUT NAK
// - SETUP data always answered with ACK
// - Software sets control stall; SETUP clears it
// - Snoop passes OUT data without CRC check
// - Type field: control, iso, bulk, interrupt
// - NAK bit refuses OUT; non-iso IN answered with NAK
// - NAK on iso IN sends zero-length packet
// - Toggle bit gives DATA0/DATA1, set by commands
// - Iso uses bit as frame parity, except in SG mode
// - USB reset clears active bit except EP0
// - Next-fetch endpoint readable while disabled
// - Clear EP0 enable before its interrupts
// - DMA SETUP move needs EP0 enable
// - EP0 OUT disable command is ignored
// - Set-NAK sets, clear-NAK clears, core sets it on EP0 only
// - EP0 reads control type, always active
// - NYET sent sets write-one-clear flag
// - NAK or iso no-data ZLP sets flag
// - Babble received sets write-one-clear flag
// - Dropped iso OUT sets unmasked flag
module udec_top #(
    parameter int MPS_W  = 11,
    parameter int NEXT_W = 4
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Token and event side, same clock
    input  wire logic        tok_valid,
    input  wire logic [1:0]  tok_type,
    input  wire logic        tok_in_ep,
    input  wire logic        rx_crc_ok,
    input  wire logic        rx_space,
    input  wire logic        tx_avail,
    input  wire logic        frame_odd,
    input  wire logic        host_ack,
    input  wire logic        glb_out_nak,
    input  wire logic        glb_in_nak,
    input  wire logic        dma_mode,
    input  wire logic        sg_mode,
    input  wire logic        usb_reset,
    input  wire logic        setup_done_evt,
    input  wire logic        xfer_done_evt,
    input  wire logic        nyet_evt,
    input  wire logic        nak_rx_evt,
    input  wire logic        babble_evt,
    input  wire logic        iso_drop_evt,
    // Answers
    output logic             hs_valid,
    output logic      [2:0]  hs_code,
    output logic             tx_pid,
    output logic             rx_to_mem,
    output logic             setup_to_mem,
    output logic             ep0_setup_int,
    output logic             ep0_xfer_int,
    output logic      [3:0]  next_fetch_endpoint,
    output logic      [6:0]  ep0_mps_bytes
);
    // ---------------------------------------------
    // Parameter check
    // ---------------------------------------------
    // Field packing below is fixed to the register layout
    if (MPS_W != udec_pkg::W_MPS || NEXT_W != udec_pkg::W_NEXT) begin : g_chk
        $error("udec_top: MPS_W and NEXT_W must match the register fields");
    end

    // ---------------------------------------------
    // Reset release
    // ---------------------------------------------
    logic rst_n_s1_q;
    logic rst_n_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_n_s1_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_n_s1_q <= 1'b1;
            rst_n_q    <= rst_n_s1_q;
        end
    end

    // ---------------------------------------------
    // State
    // ---------------------------------------------
    udec_pkg::udec_bus_t bus_q;
    logic [31:0]        rdata_q;
    logic               wait_q;
    logic               in_en_q, in_dis_q, in_stall_q, in_nak_q;
    logic               in_data_toggle_bit_q, in_act_q;
    logic [3:0]         in_txf_q;
    logic [1:0]         in_type_q;
    logic [NEXT_W-1:0]  in_next_q;
    logic [MPS_W-1:0]   in_mps_q;
    logic [1:0]         mps0_q;
    logic               e0_en_q, e0_stall_q, e0_snp_q, e0_nak_q;
    logic               f_nyet_q, f_nak_q, f_bbl_q, f_drop_q;
    logic               hs_valid_q, tx_pid_q, rx_mem_q, su_mem_q;
    logic               su_int_q, xf_int_q;
    logic [2:0]         hs_code_q;
    logic [6:0]         mps_bytes_q;

    // ---------------------------------------------
    // Bus decode
    // ---------------------------------------------
    // Master holds the request; write lands when wait is low
    wire        bus_req = avs_read | avs_write;
    wire        ans     = bus_q == udec_pkg::BS_ANS;
    wire        wr_go   = avs_write & ans;
    wire [31:0] wm      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wd      = avs_writedata & wm;
    wire        wr_in   = wr_go & (avs_address == udec_pkg::A_IN_CTL);
    wire        wr_e0   = wr_go & (avs_address == udec_pkg::A_EP0_CTL);
    wire        wr_int  = wr_go & (avs_address == udec_pkg::A_OUT_INT);
    wire        wr_m0   = wr_go & (avs_address == udec_pkg::A_IN0_MPS);

    // ---------------------------------------------
    // Read words
    // ---------------------------------------------
    wire        in_iso  = in_type_q == udec_pkg::T_ISO;
    wire        data_toggle_bit_rd = in_data_toggle_bit_q & ~(in_iso & sg_mode);
    wire [31:0] rd_in   = {in_en_q, in_dis_q, 4'h0, in_txf_q, in_stall_q, 1'b0,
                           in_type_q, in_nak_q, data_toggle_bit_rd, in_act_q, in_next_q,
                           in_mps_q};
    // Endpoint 0 type and active bit are constants
    wire [31:0] rd_e0   = {e0_en_q, 9'h000, e0_stall_q, e0_snp_q,
                           udec_pkg::T_CTRL, e0_nak_q, 1'b0, 1'b1, 13'h0000,
                           mps0_q};
    wire [31:0] rd_int  = {17'h00000, f_nyet_q, f_nak_q, f_bbl_q, f_drop_q,
                           11'h000};
    wire [31:0] rd_m0   = {30'h0000_0000, mps0_q};
    wire [31:0] rd_word =
        (avs_address == udec_pkg::A_IN_CTL)  ? rd_in  :
        (avs_address == udec_pkg::A_EP0_CTL) ? rd_e0  :
        (avs_address == udec_pkg::A_OUT_INT) ? rd_int :
        (avs_address == udec_pkg::A_IN0_MPS) ? rd_m0  : udec_pkg::RD_NONE;
    // Byte-lane merge for read-write fields
    wire [31:0] in_new  = (rd_in & ~wm) | wd;
    wire [31:0] e0_new  = (rd_e0 & ~wm) | wd;

    // ---------------------------------------------
    // Bus slave: one wait cycle, then answer
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bus_q   <= udec_pkg::BS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= udec_pkg::RD_NONE;
        end else begin
            case (bus_q)
                udec_pkg::BS_IDLE: begin
                    if (bus_req) begin
                        bus_q   <= udec_pkg::BS_ANS;
                        wait_q  <= 1'b0;
                        rdata_q <= rd_word;
                    end
                end
                udec_pkg::BS_ANS: begin
                    bus_q  <= udec_pkg::BS_IDLE;
                    wait_q <= 1'b1;
                end
                default: begin
                    bus_q  <= udec_pkg::BS_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // ---------------------------------------------
    // Token decode and handshake choice
    // ---------------------------------------------
    wire tk_setup = tok_valid & ~tok_in_ep & (tok_type == udec_pkg::TK_SETUP);
    wire tk_out0  = tok_valid & ~tok_in_ep & (tok_type == udec_pkg::TK_OUT);
    wire tk_in    = tok_valid & tok_in_ep & (tok_type == udec_pkg::TK_IN);
    // Parity mismatch means the data belongs to another frame
    wire iso_hold = in_nak_q | ~in_en_q | (~sg_mode & (in_data_toggle_bit_q != frame_odd));
    wire [2:0] hs_out0 =
        e0_stall_q                ? udec_pkg::HS_STALL :
        (e0_nak_q | glb_out_nak)  ? udec_pkg::HS_NAK   :
        ~rx_space                 ? udec_pkg::HS_NAK   :
        (~rx_crc_ok & ~e0_snp_q)  ? udec_pkg::HS_NONE  :
                                    udec_pkg::HS_ACK;
    wire [2:0] hs_iso =
        (iso_hold | ~tx_avail)    ? udec_pkg::HS_ZLP   :
                                    udec_pkg::HS_DATA;
    wire [2:0] hs_bulk =
        in_stall_q                ? udec_pkg::HS_STALL :
        (in_nak_q | glb_in_nak)   ? udec_pkg::HS_NAK   :
        (~in_en_q | ~tx_avail)    ? udec_pkg::HS_NAK   :
                                    udec_pkg::HS_DATA;
    wire [2:0] hs_d =
        tk_setup ? udec_pkg::HS_ACK :
        tk_out0  ? hs_out0 :
        tk_in    ? (in_iso ? hs_iso : hs_bulk) : udec_pkg::HS_NONE;
    wire nak_sent = (hs_d == udec_pkg::HS_NAK)
                  | (tk_in & in_iso & ~tx_avail);
    wire e0_done  = setup_done_evt | xfer_done_evt;
    wire [6:0] mps_d =
        (mps0_q == 2'h0) ? udec_pkg::MPS_64 :
        (mps0_q == 2'h1) ? udec_pkg::MPS_32 :
        (mps0_q == 2'h2) ? udec_pkg::MPS_16 : udec_pkg::MPS_8;

    // ---------------------------------------------
    // Answer registers
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hs_valid_q  <= 1'b0;
            hs_code_q   <= udec_pkg::HS_NONE;
            tx_pid_q    <= 1'b0;
            rx_mem_q    <= 1'b0;
            su_mem_q    <= 1'b0;
            mps_bytes_q <= udec_pkg::MPS_64;
        end else begin
            hs_valid_q  <= hs_d != udec_pkg::HS_NONE;
            hs_code_q   <= hs_d;
            tx_pid_q    <= in_data_toggle_bit_q & ~in_iso;
            rx_mem_q    <= tk_out0 & (hs_out0 == udec_pkg::HS_ACK);
            su_mem_q    <= tk_setup & (~dma_mode | e0_en_q);
            mps_bytes_q <= mps_d;
        end
    end

    // ---------------------------------------------
    // IN endpoint control
    // ---------------------------------------------
    // Disable completes one cycle later and takes enable down
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            in_en_q    <= 1'b0;
            in_dis_q   <= 1'b0;
            in_txf_q   <= 4'h0;
            in_stall_q <= 1'b0;
            in_type_q  <= udec_pkg::T_CTRL;
            in_nak_q   <= 1'b0;
            in_data_toggle_bit_q  <= 1'b0;
            in_act_q   <= 1'b0;
            in_next_q  <= '0;
            in_mps_q   <= '0;
        end else begin
            if (in_dis_q) begin
                in_en_q  <= 1'b0;
                in_dis_q <= 1'b0;
            end else if (wr_in) begin
                in_en_q  <= in_en_q | wd[udec_pkg::B_EN];
                in_dis_q <= wd[udec_pkg::B_DIS] & in_en_q;
            end
            if (wr_in) begin
                in_txf_q   <= in_new[udec_pkg::B_TXF +: 4];
                in_stall_q <= in_new[udec_pkg::B_STALL];
                in_type_q  <= in_new[udec_pkg::B_TYPE +: 2];
                in_next_q  <= in_new[udec_pkg::B_NEXT +: NEXT_W];
                in_mps_q   <= in_new[MPS_W-1:0];
            end
            if (wr_in & wd[udec_pkg::B_SET_NAK_CMD]) begin
                in_nak_q <= 1'b1;
            end else if (wr_in & wd[udec_pkg::B_CLEAR_NAK_CMD]) begin
                in_nak_q <= 1'b0;
            end
            // Commands win over the toggle; parity commands dead in SG
            if (wr_in & wd[udec_pkg::B_SD1] & ~(in_iso & sg_mode)) begin
                in_data_toggle_bit_q <= 1'b1;
            end else if (wr_in & wd[udec_pkg::B_SD0] & ~(in_iso & sg_mode)) begin
                in_data_toggle_bit_q <= 1'b0;
            end else if (host_ack & ~in_iso) begin
                in_data_toggle_bit_q <= ~in_data_toggle_bit_q;
            end
            if (usb_reset) begin
                in_act_q <= 1'b0;
            end else if (wr_in) begin
                in_act_q <= in_new[udec_pkg::B_ACT];
            end
        end
    end

    // ---------------------------------------------
    // OUT endpoint 0 control
    // ---------------------------------------------
    // Disable bit has no storage: only a setup or transfer done event clears enable
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            e0_en_q    <= 1'b0;
            e0_stall_q <= 1'b0;
            e0_snp_q   <= 1'b0;
            e0_nak_q   <= 1'b0;
            mps0_q     <= 2'h0;
            su_int_q   <= 1'b0;
            xf_int_q   <= 1'b0;
        end else begin
            if (e0_done) begin
                e0_en_q <= 1'b0;
            end else if (wr_e0 & wd[udec_pkg::B_EN]) begin
                e0_en_q <= 1'b1;
            end
            // Pulse and enable clear share an edge: no interrupt ever sees enable high
            su_int_q <= setup_done_evt;
            xf_int_q <= xfer_done_evt;
            if (wr_e0 & wd[udec_pkg::B_STALL]) begin
                e0_stall_q <= 1'b1;
            end else if (tk_setup) begin
                e0_stall_q <= 1'b0;
            end
            if (wr_e0) begin
                e0_snp_q <= e0_new[udec_pkg::B_SNP];
            end
            if ((wr_e0 & wd[udec_pkg::B_SET_NAK_CMD]) | tk_setup | xfer_done_evt) begin
                e0_nak_q <= 1'b1;
            end else if (wr_e0 & wd[udec_pkg::B_CLEAR_NAK_CMD]) begin
                e0_nak_q <= 1'b0;
            end
            if (wr_m0) begin
                mps0_q <= ((mps0_q & ~wm[1:0]) | wd[1:0]);
            end
        end
    end

    // ---------------------------------------------
    // OUT interrupt flags, write one to clear
    // ---------------------------------------------
    // A new event in the clearing cycle keeps the flag set
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            f_nyet_q <= 1'b0;
            f_nak_q  <= 1'b0;
            f_bbl_q  <= 1'b0;
            f_drop_q <= 1'b0;
        end else begin
            f_nyet_q <= nyet_evt | (f_nyet_q & ~(wr_int & wd[udec_pkg::B_NYET]));
            f_nak_q  <= nak_sent | nak_rx_evt
                      | (f_nak_q & ~(wr_int & wd[udec_pkg::B_NAKI]));
            f_bbl_q  <= babble_evt | (f_bbl_q & ~(wr_int & wd[udec_pkg::B_BBL]));
            f_drop_q <= iso_drop_evt
                      | (f_drop_q & ~(wr_int & wd[udec_pkg::B_DROP]));
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    assign avs_readdata        = rdata_q;
    assign avs_waitrequest     = wait_q;
    assign hs_valid            = hs_valid_q;
    assign hs_code             = hs_code_q;
    assign tx_pid              = tx_pid_q;
    assign rx_to_mem           = rx_mem_q;
    assign setup_to_mem        = su_mem_q;
    assign ep0_setup_int       = su_int_q;
    assign ep0_xfer_int        = xf_int_q;
    assign next_fetch_endpoint = in_next_q;
    assign ep0_mps_bytes       = mps_bytes_q;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_q);

    sequence s_e0_done;
        setup_done_evt || xfer_done_evt;
    endsequence
    sequence s_int_enable_low;
        !e0_en_q && (ep0_setup_int || ep0_xfer_int);
    endsequence

    chk_stall_wins: assert property (
        tk_out0 && e0_stall_q |=> hs_valid && hs_code == udec_pkg::HS_STALL)
        else $error("stall did not win on OUT token");
    chk_setup_ack: assert property (
        tk_setup |=> hs_valid && hs_code == udec_pkg::HS_ACK)
        else $error("SETUP not acknowledged");
    chk_setup_unstall: assert property (
        tk_setup && !wr_e0 |=> !e0_stall_q)
        else $error("SETUP left stall set");
    chk_snoop_pass: assert property (
        tk_out0 && e0_snp_q && !e0_stall_q && !e0_nak_q && !glb_out_nak
        && rx_space |=> rx_to_mem)
        else $error("snoop OUT packet not passed");
    chk_in_nak: assert property (
        tk_in && !in_iso && in_nak_q && !in_stall_q
        |=> hs_code == udec_pkg::HS_NAK)
        else $error("non-iso IN sent data under NAK");
    chk_iso_zlp: assert property (
        tk_in && in_iso && in_nak_q |=> hs_code == udec_pkg::HS_ZLP)
        else $error("iso IN under NAK not zero length");
    chk_toggle_one: assert property (
        wr_in && wd[udec_pkg::B_SD1] && !in_iso |=> in_data_toggle_bit_q)
        else $error("set DATA1 command lost");
    chk_reset_inact: assert property (
        usb_reset |=> !in_act_q)
        else $error("USB reset left endpoint active");
    chk_en_before_int: assert property (
        s_e0_done |=> s_int_enable_low)
        else $error("EP0 interrupt before enable cleared");
    chk_ep0_fixed: assert property (
        bus_q == udec_pkg::BS_IDLE && avs_read
        && avs_address == udec_pkg::A_EP0_CTL
        |=> avs_readdata[udec_pkg::B_ACT] && avs_readdata[19:18] == 2'h0)
        else $error("EP0 type or active bit wrong");
    chk_nyet_flag: assert property (
        nyet_evt |=> f_nyet_q)
        else $error("NYET flag not set");
    chk_babble_hold: assert property (
        f_bbl_q && !wr_int |=> f_bbl_q)
        else $error("babble flag dropped without clear");
endmodule // udec_top

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    // Stimulus and observed signals
    logic        mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, v;
    logic [3:0]  avs_byteenable = 4'hf, tq, next_fetch_endpoint;
    logic [6:0]  ev = 7'h00, ep0_mps_bytes, ans;
    logic        dma = 1'b0, zero = 1'b0, avs_waitrequest, tok_valid, tok_in_ep;
    logic        hs_valid, tx_pid, rx_to_mem, setup_to_mem, ep0_setup_int, ep0_xfer_int;
    logic [1:0]  tok_type;
    logic [2:0]  hs_code;
    int          failures = 0, check_count = 0, cyc = 0;

    udec_top dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .tok_valid, .tok_type,
        .tok_in_ep, .rx_crc_ok(tq[3]), .rx_space(tq[2]), .tx_avail(tq[1]),
        .frame_odd(tq[0]), .host_ack(zero), .glb_out_nak(zero), .glb_in_nak(zero),
        .dma_mode(dma), .sg_mode(zero), .usb_reset(ev[0]), .setup_done_evt(ev[1]),
        .xfer_done_evt(ev[2]), .nyet_evt(ev[3]), .nak_rx_evt(ev[4]), .babble_evt(ev[5]),
        .iso_drop_evt(ev[6]), .hs_valid, .hs_code, .tx_pid, .rx_to_mem, .setup_to_mem,
        .ep0_setup_int, .ep0_xfer_int, .next_fetch_endpoint, .ep0_mps_bytes);
    udec_host_model h (.mclk, .hs_valid, .hs_code, .tx_pid, .rx_to_mem, .setup_to_mem,
        .tok_valid, .tok_type, .tok_in_ep, .tok_qual(tq));

    // Clock and hang guard
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic ev_pulse(input int i);
        @(posedge mclk);
        ev <= 7'h01 << i;
        @(posedge mclk);
        ev <= 7'h00;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int t = 0; t < 4; t++) begin
            bus(1'b1, 12'h920, {12'h000, t[1:0], 18'h00000});
            bus(1'b0, 12'h920, 32'h0);
            chk("type", v[19:18], t[1:0]);
        end
        bus(1'b1, 12'h920, 32'h2008_a840);
        bus(1'b0, 12'h920, 32'h0);
        chk("in_ctl", v, 32'h0009_a840);
        chk("next_ep", next_fetch_endpoint, 32'h5);
        bus(1'b1, 12'h920, 32'h8008_a840);
        h.send(udec_pkg::TK_IN, 1'b1, 4'h2, ans);
        chk("data", ans[6:2], {1'b1, udec_pkg::HS_DATA, 1'b1});
        bus(1'b1, 12'h920, 32'h8808_a840);
        h.send(udec_pkg::TK_IN, 1'b1, 4'h2, ans);
        chk("nak", ans[6:3], {1'b1, udec_pkg::HS_NAK});
        bus(1'b0, 12'h920, 32'h0);
        chk("nak_bit", v[17], 32'h1);
        bus(1'b1, 12'h920, 32'h8028_a840);
        h.send(udec_pkg::TK_IN, 1'b1, 4'h2, ans);
        chk("stall", ans[6:3], {1'b1, udec_pkg::HS_STALL});
        bus(1'b1, 12'h920, 32'h8804_a840);
        h.send(udec_pkg::TK_IN, 1'b1, 4'h2, ans);
        chk("zlp", ans[6:3], {1'b1, udec_pkg::HS_ZLP});
        bus(1'b1, 12'h920, 32'h1004_a840);
        bus(1'b0, 12'h920, 32'h0);
        chk("even", v[16], 32'h0);
        ev_pulse(0);
        bus(1'b0, 12'h920, 32'h0);
        chk("active", v[15], 32'h0);
        bus(1'b0, 12'hb00, 32'h0);
        chk("ep0_fixed", v[19:15], 32'h01);
        // Endpoint 0: stall with NAK, then SETUP with and without enable
        bus(1'b1, 12'hb00, 32'h0820_0000);
        h.send(udec_pkg::TK_OUT, 1'b0, 4'hc, ans);
        chk("ep0_stall", ans[6:3], {1'b1, udec_pkg::HS_STALL});
        dma <= 1'b1;
        h.send(udec_pkg::TK_SETUP, 1'b0, 4'hc, ans);
        chk("setup_ack", ans[6:3], {1'b1, udec_pkg::HS_ACK});
        chk("setup_mem", ans[0], 32'h0);
        bus(1'b0, 12'hb00, 32'h0);
        chk("ep0_ctl", v[21:15], 32'h05);
        bus(1'b1, 12'hb00, 32'h8000_0000);
        h.send(udec_pkg::TK_SETUP, 1'b0, 4'hc, ans);
        chk("setup_mem", ans[0], 32'h1);
        bus(1'b1, 12'hb00, 32'h4000_0000);
        bus(1'b0, 12'hb00, 32'h0);
        chk("ep0_en", v[31], 32'h1);
        ev_pulse(1);
        #1 chk("setup_int", ep0_setup_int, 32'h1);
        bus(1'b0, 12'hb00, 32'h0);
        chk("ep0_en", v[31], 32'h0);
        ev_pulse(2);
        #1 chk("xfer_int", ep0_xfer_int, 32'h1);
        bus(1'b1, 12'hb00, 32'h8410_0000);
        h.send(udec_pkg::TK_OUT, 1'b0, 4'h4, ans);
        chk("snoop", ans[1], 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 12'h900, i);
            bus(1'b0, 12'hb00, 32'h0);
            chk("mps_code", v[1:0], i);
            chk("mps_bytes", ep0_mps_bytes, 7'h40 >> i);
        end
        bus(1'b0, 12'h004, 32'h0);
        chk("unmapped", v, 32'h0);
        // The NAK answered on the bulk IN token earlier is still flagged
        bus(1'b0, 12'hb08, 32'h0);
        chk("nak_flag", v, 32'h2000);
        bus(1'b1, 12'hb08, v);
        for (int i = 3; i < 7; i++) begin
            ev_pulse(i);
            bus(1'b0, 12'hb08, 32'h0);
            chk("flag", v, 32'h1 << (17 - i));
            bus(1'b1, 12'hb08, v);
            bus(1'b0, 12'hb08, 32'h0);
            chk("flag_clr", v, 32'h0);
        end
        give_verdict();
    end
endmodule // testbench

// File: dv/udec_host_model.sv
`timescale 1ns/1ps
// Host across the bus: sends one token, then reads the one-cycle answer
module udec_host_model (
    // Clock
    input  wire logic       mclk,
    // Answers from the endpoint logic
    input  wire logic       hs_valid,
    input  wire logic [2:0] hs_code,
    input  wire logic       tx_pid,
    input  wire logic       rx_to_mem,
    input  wire logic       setup_to_mem,
    // Token and qualifiers {crc ok, space, data, odd frame}
    output logic            tok_valid,
    output logic      [1:0] tok_type,
    output logic            tok_in_ep,
    output logic      [3:0] tok_qual
);
    // Idle bus
    initial begin
        tok_valid = 1'b0;
        tok_type  = 2'h3;
        tok_in_ep = 1'b0;
        tok_qual  = 4'h0;
    end
    // Qualifiers are scrambled after use so stale values never pass for real
    task automatic send(input logic [1:0] t, input logic i, input logic [3:0] q,
                        output logic [6:0] a);
        @(posedge mclk);
        tok_valid <= 1'b1;
        tok_type  <= t;
        tok_in_ep <= i;
        tok_qual  <= q;
        @(posedge mclk);
        tok_valid <= 1'b0;
        tok_type  <= ~t;
        tok_in_ep <= ~i;
        tok_qual  <= ~q;
        #1;
        a = {hs_valid, hs_code, tx_pid, rx_to_mem, setup_to_mem};
    endtask
endmodule // udec_host_model
